// ==== hdl/lcdbus_pkg.sv ====
// Constants, types and timing for the LCD driver two-wire command port.
// Assumes a 10 MHz system clock and an external open-drain wire resolution.
// Behaviour
// R1: The master starts a transfer only while data and clock are both high.
// R2: Data stays unchanged while clock is high; one bit per clock pulse.
// R3: Data falling with clock high is start; data rising with clock high is stop.
// R4: Each byte is eight bits plus one acknowledge pulse; byte count unlimited.
// R5: The acknowledger holds data low through the whole acknowledge pulse.
// R6: Master leaves last read byte unacknowledged; slave then releases data high.
// R7: Transmit and receive in mixed mode, receive only in row mode, never master.
// R8: Slave address is 011110 followed by the strapped select level.
// R9: Acknowledge a matching address; on mismatch ignore all until next start.
// R10: In writes, bytes after the address are commands, each acknowledged.
// R11: Bit 7 is continuation; once clear, the remaining bytes are display data.
// R12: Acknowledge display data only when the subaddress counter equals zero.
// R13: Store display data only when the subaddress counter equals zero.
// R14: In reads, send display bytes right after the address acknowledge.
// R15: Each display byte uses the data pointer, which then auto-advances.
// R16: Display memory holds four banks of forty bytes.
// R17: Columns 0 to 7 are storage only; other columns map to outputs directly.
// R18: Bits 6:5 equal 10 decode set-mode: mode flag, status, drive mode.
// R19: Bits 6:2 all set decode set-start-bank with bank in bits 1:0.
// R20: Bits 6:4 equal 111, bits 3:2 not both set decode memory access.
// R21: Bits 6:4 equal 110 decode device-select with subaddress in bits 3:0.
// R22: Bit 6 clear decodes load-column with six bits; commands only in writes.
// R23: Continuation 0 makes next byte data; continuation 1 makes it a command.
// R24: Device-select copies its four bits into the subaddress counter.
// R25: Reset blanks, row mode 1:32, bank 0, character access, pointer 0,0.
// R26: The master waits at least 1 ms after power-on before any transfer.
// R27: Clock and data pass synchronisers and a glitch filter before edges.
package lcdbus_pkg;
   localparam logic [5:0] SLV_ADDR_HI = 6'h1E;
   localparam logic [3:0] HW_SUBADDR = 4'h0;
   localparam int BANKS = 4;
   localparam int COLS = 40;
   localparam logic [5:0] X_LAST = 6'h27;
   localparam logic [1:0] Y_LAST = 2'h3;
   localparam logic [5:0] X_FIRST_SHOWN = 6'h08;
   localparam int CONT_BIT = 7;
   localparam logic [1:0] OP_MODE = 2'h2;
   localparam logic [4:0] OP_BANK = 5'h1F;
   localparam logic [2:0] OP_RAM = 3'h7;
   localparam logic [2:0] OP_DEVSEL = 3'h6;
   localparam logic [3:0] BYTE_LAST = 4'h7;
   localparam logic [3:0] ACK_DRIVE = 4'h8;
   localparam logic [3:0] ACK_END = 4'h9;
   localparam logic [7:0] IDLE_BYTE = 8'hFF;
   localparam logic MODE_ROW = 1'b0;
   localparam logic [1:0] STATUS_BLANK = 2'h0;
   localparam logic [1:0] DRIVE_MUX32 = 2'h0;
   localparam logic [1:0] ACCESS_CHAR = 2'h0;
   localparam int CLK_FREQ_HZ = 10_000_000;
   localparam int POR_TIME_US = 1000;
   localparam int POR_CYCLES_DEF = POR_TIME_US * (CLK_FREQ_HZ / 1_000_000);
   localparam int FILT_LEN_DEF = 3;

   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_RDATA, ST_IGNORE} lcdbus_state_e;

   typedef struct packed {
      logic mixed;
      logic [1:0] status;
      logic [1:0] drive;
      logic [1:0] bank;
      logic [1:0] access;
   } lcdbus_cfg_s;

   typedef struct packed {
      logic [3:0] sub;
      logic [1:0] y;
      logic [5:0] x;
   } lcdbus_ptr_s;

   localparam lcdbus_cfg_s CFG_RESET = '{mixed: MODE_ROW, status: STATUS_BLANK, drive: DRIVE_MUX32,
                                         bank: 2'h0, access: ACCESS_CHAR};
endpackage

// ==== hdl/lcdbus_port.sv ====
// Two-wire slave command port with display memory for the LCD driver.
// Assumes pins arrive asynchronously and the wire is resolved outside from o_sda_oe.
`timescale 1ns/10ps
module lcdbus_port import lcdbus_pkg::*; #(
   parameter int FILT_LEN = FILT_LEN_DEF,
   parameter int POR_CYCLES = POR_CYCLES_DEF
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   input wire logic i_scl,
   input wire logic i_sda_in,
   input wire logic i_address_select_strap,
   input wire logic [1:0] i_disp_bank,
   input wire logic [5:0] i_disp_col,
   output logic o_sda_out,
   output logic o_sda_oe,
   output logic o_busy,
   output lcdbus_cfg_s o_cfg,
   output lcdbus_ptr_s o_ptr,
   output logic [7:0] o_disp_data
);
   localparam int PORW = $clog2(POR_CYCLES + 1);

   // Refuse filter depths and wait counts the logic cannot serve
   if (FILT_LEN < 2 || FILT_LEN > 16) begin : g_bad_filt
      $error("FILT_LEN out of range");
   end
   if (POR_CYCLES < 1) begin : g_bad_por
      $error("POR_CYCLES must be positive");
   end

   function automatic logic [7:0] ram_idx(input logic [1:0] y, input logic [5:0] x);
      ram_idx = 8'(8'(y) * 8'(COLS) + 8'(x));
   endfunction

   logic [2:0] sync1_ff, sync2_ff;
   logic [1:0] filt_w, prev_ff;
   logic [PORW-1:0] por_cnt_ff;
   lcdbus_state_e st_ff;
   logic [3:0] cnt_ff;
   logic [7:0] shr_ff;
   logic pend_ff, mack_ff;
   lcdbus_cfg_s cfg_ff;
   lcdbus_ptr_s ptr_ff;
   logic [7:0] ram_ff [BANKS*COLS];
   logic [7:0] disp_ff;
   logic sda_out_ff, oe_ff;
   logic busy_ff;

   // Two-stage synchronisers, then a stability filter on clock and data [R27]
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         sync1_ff <= 3'h7;
         sync2_ff <= 3'h7;
      end else if (i_ce) begin
         sync1_ff <= {i_address_select_strap, i_scl, i_sda_in};
         sync2_ff <= sync1_ff;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_filt
         logic [FILT_LEN-1:0] hist_ff;
         logic line_ff;
         wire steady = (&hist_ff) | ~(|hist_ff);
         assign filt_w[gi] = line_ff;
         always_ff @(posedge i_clk) begin
            if (!i_nrst) begin
               hist_ff <= '1;
               line_ff <= 1'b1;
            end else if (i_ce) begin
               hist_ff <= {hist_ff[FILT_LEN-2:0], sync2_ff[gi]};
               if (steady) begin
                  line_ff <= hist_ff[0]; // [R27]
               end
            end
         end
      end
   endgenerate

   wire sda_f = filt_w[0];
   wire scl_f = filt_w[1];
   wire strap = sync2_ff[2];
   wire por_busy = (por_cnt_ff != '0);
   wire live = i_ce & ~por_busy;
   wire scl_rise = live & scl_f & ~prev_ff[1];
   wire scl_fall = live & ~scl_f & prev_ff[1];
   wire start_det = live & scl_f & prev_ff[1] & ~sda_f & prev_ff[0]; // [R3]
   wire stop_det = live & scl_f & prev_ff[1] & sda_f & ~prev_ff[0]; // [R3]

   // Byte assembly and decode
   wire [7:0] rx_byte = {shr_ff[6:0], sda_f};
   wire rx_state = (st_ff == ST_ADDR) | (st_ff == ST_CMD) | (st_ff == ST_WDATA);
   wire byte_done = scl_rise & rx_state & (cnt_ff == BYTE_LAST); // [R4]
   wire addr_match = (rx_byte[7:1] == {SLV_ADDR_HI, strap}); // [R8]
   wire rd_req = rx_byte[0];
   wire rd_ok = ~rd_req | cfg_ff.mixed; // [R7]
   wire addr_done = byte_done & (st_ff == ST_ADDR);
   wire cmd_done = byte_done & (st_ff == ST_CMD);
   wire data_done = byte_done & (st_ff == ST_WDATA);
   wire dec_mode = (rx_byte[6:5] == OP_MODE); // [R18]
   wire dec_bank = (rx_byte[6:2] == OP_BANK); // [R19]
   wire dec_ram = (rx_byte[6:4] == OP_RAM) & ~(&rx_byte[3:2]); // [R20]
   wire dec_devsel = (rx_byte[6:4] == OP_DEVSEL); // [R21]
   wire dec_loadx = ~rx_byte[6]; // [R22]
   wire sub_hit = (ptr_ff.sub == HW_SUBADDR); // [R12] [R13]
   wire x_ok = (ptr_ff.x <= X_LAST);
   wire [7:0] cur_idx = ram_idx(ptr_ff.y, ptr_ff.x);
   wire wr_en = data_done & sub_hit & x_ok; // [R13]
   wire tx_load = scl_fall & (st_ff == ST_RDATA) & (cnt_ff == ACK_END) & mack_ff; // [R14]
   wire [7:0] tx_byte = (sub_hit & x_ok) ? ram_ff[cur_idx] : IDLE_BYTE;
   wire advance = data_done | tx_load; // [R15]

   // Next pointer: column, then row, then subaddress
   wire x_wrap = (ptr_ff.x >= X_LAST);
   wire y_wrap = x_wrap & (ptr_ff.y == Y_LAST);
   wire [5:0] nxt_x = x_wrap ? 6'h00 : 6'(ptr_ff.x + 6'h01);
   wire [1:0] nxt_y = x_wrap ? 2'(ptr_ff.y + 2'h1) : ptr_ff.y;
   wire [3:0] nxt_sub = y_wrap ? 4'(ptr_ff.sub + 4'h1) : ptr_ff.sub;

   // State after a completed byte
   lcdbus_state_e nxt_st;
   logic nxt_pend;
   always_comb begin
      nxt_st = st_ff;
      nxt_pend = 1'b0;
      case (st_ff)
         ST_ADDR: begin
            nxt_pend = addr_match & rd_ok; // [R9]
            nxt_st = !nxt_pend ? ST_IGNORE : (rd_req ? ST_RDATA : ST_CMD); // [R9] [R10] [R14]
         end
         ST_CMD: begin
            nxt_pend = 1'b1; // [R10]
            nxt_st = rx_byte[CONT_BIT] ? ST_CMD : ST_WDATA; // [R11] [R23]
         end
         ST_WDATA: begin
            nxt_pend = sub_hit; // [R12]
         end
         default: begin
            nxt_st = st_ff;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         por_cnt_ff <= PORW'(POR_CYCLES);
         prev_ff <= 2'h3;
         busy_ff <= 1'b1;
      end else if (i_ce) begin
         prev_ff <= filt_w;
         busy_ff <= (por_cnt_ff > PORW'(1)); // [R25]
         if (por_busy) begin
            por_cnt_ff <= PORW'(por_cnt_ff - 1'b1);
         end
      end
   end

   // Bus protocol engine
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         st_ff <= ST_IDLE;
         cnt_ff <= 4'h0;
         shr_ff <= 8'h00;
         pend_ff <= 1'b0;
         mack_ff <= 1'b0;
         oe_ff <= 1'b0;
      end else if (start_det) begin
         st_ff <= ST_ADDR; // [R3] [R9]
         cnt_ff <= 4'h0;
         oe_ff <= 1'b0;
      end else if (stop_det) begin
         st_ff <= ST_IDLE; // [R3]
         oe_ff <= 1'b0;
      end else if (st_ff != ST_IDLE && st_ff != ST_IGNORE) begin
         if (scl_rise) begin
            if (cnt_ff < ACK_DRIVE) begin
               cnt_ff <= 4'(cnt_ff + 4'h1); // [R2] [R4]
               if (rx_state) begin
                  shr_ff <= rx_byte;
               end
            end
            if (cnt_ff == ACK_END && st_ff == ST_RDATA) begin
               mack_ff <= ~sda_f; // [R6]
            end
            if (byte_done) begin
               pend_ff <= nxt_pend;
               mack_ff <= 1'b1;
               st_ff <= nxt_st;
            end
         end
         if (scl_fall) begin
            if (cnt_ff == ACK_DRIVE) begin
               oe_ff <= pend_ff; // [R5]
               cnt_ff <= ACK_END;
            end else if (cnt_ff == ACK_END) begin
               cnt_ff <= 4'h0;
               pend_ff <= 1'b0;
               if (tx_load) begin
                  oe_ff <= ~tx_byte[7]; // [R14]
                  shr_ff <= {tx_byte[6:0], 1'b1};
               end else begin
                  oe_ff <= 1'b0; // [R5] [R6]
                  if (st_ff == ST_RDATA) begin
                     st_ff <= ST_IGNORE; // [R6]
                  end
               end
            end else if (st_ff == ST_RDATA && cnt_ff != 4'h0) begin
               oe_ff <= ~shr_ff[7]; // [R2]
               shr_ff <= {shr_ff[6:0], 1'b1};
            end
         end
      end
   end

   // Command registers and data pointer
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         cfg_ff <= CFG_RESET; // [R25]
         ptr_ff <= '0; // [R25]
      end else if (i_ce) begin
         if (cmd_done) begin
            if (dec_mode) begin
               cfg_ff.mixed <= rx_byte[4]; // [R18]
               cfg_ff.status <= rx_byte[3:2];
               cfg_ff.drive <= rx_byte[1:0];
            end
            if (dec_bank) begin
               cfg_ff.bank <= rx_byte[1:0]; // [R19]
            end
            if (dec_ram) begin
               cfg_ff.access <= rx_byte[3:2]; // [R20]
               ptr_ff.y <= rx_byte[1:0];
            end
            if (dec_devsel) begin
               ptr_ff.sub <= rx_byte[3:0]; // [R24]
            end
            if (dec_loadx) begin
               ptr_ff.x <= rx_byte[5:0]; // [R22]
            end
         end else if (advance) begin
            ptr_ff <= '{sub: nxt_sub, y: nxt_y, x: nxt_x}; // [R15]
         end
      end
   end

   // Display memory, 4 x 40 bytes, plus display-side read port
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         disp_ff <= 8'h00;
         sda_out_ff <= 1'b0;
      end else if (i_ce) begin
         if (wr_en) begin
            ram_ff[cur_idx] <= rx_byte; // [R13] [R16]
         end
         if (i_disp_col >= X_FIRST_SHOWN && i_disp_col <= X_LAST) begin
            disp_ff <= ram_ff[ram_idx(i_disp_bank, i_disp_col)]; // [R17]
         end else begin
            disp_ff <= 8'h00; // [R17]
         end
      end
   end

   assign o_sda_out = sda_out_ff;
   assign o_sda_oe = oe_ff;
   assign o_busy = busy_ff;
   assign o_cfg = cfg_ff;
   assign o_ptr = ptr_ff;
   assign o_disp_data = disp_ff;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   property p_start_addr;
      start_det |=> st_ff == ST_ADDR && cnt_ff == 4'h0 && !oe_ff;
   endproperty
   a_start_addr: assert property (p_start_addr) else $error("start not taken"); // [R3]
   property p_stop_idle;
      stop_det && !start_det |=> st_ff == ST_IDLE && !oe_ff;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("stop not taken"); // [R3]
   property p_ack_low;
      scl_fall && cnt_ff == ACK_DRIVE && pend_ff && !start_det && !stop_det |=> oe_ff && cnt_ff == ACK_END;
   endproperty
   a_ack_low: assert property (p_ack_low) else $error("acknowledge not driven"); // [R5]
   property p_oe_steady;
      ##1 $changed(oe_ff) |-> $past(scl_fall || start_det || stop_det);
   endproperty
   a_oe_steady: assert property (p_oe_steady) else $error("data moved while clock high"); // [R2]
   property p_mismatch;
      addr_done && !addr_match && !start_det && !stop_det |=> st_ff == ST_IGNORE ##1 !oe_ff;
   endproperty
   a_mismatch: assert property (p_mismatch) else $error("foreign address answered"); // [R8]
   property p_row_read;
      addr_done && rd_req && !cfg_ff.mixed && !start_det && !stop_det |=> st_ff == ST_IGNORE;
   endproperty
   a_row_read: assert property (p_row_read) else $error("read accepted in row mode"); // [R7]
   property p_ignore_quiet;
      st_ff == ST_IGNORE |-> !oe_ff;
   endproperty
   a_ignore_quiet: assert property (p_ignore_quiet) else $error("ignored transfer drives data"); // [R9]
   property p_cont;
      cmd_done && !rx_byte[CONT_BIT] && !start_det && !stop_det |=> st_ff == ST_WDATA;
   endproperty
   a_cont: assert property (p_cont) else $error("data phase not entered"); // [R11]
   property p_store_sub;
      wr_en |-> ptr_ff.sub == HW_SUBADDR ##1 ram_ff[$past(cur_idx)] == $past(rx_byte);
   endproperty
   a_store_sub: assert property (p_store_sub) else $error("store with foreign subaddress"); // [R13]
   property p_x_step;
      advance && !cmd_done && ptr_ff.x < X_LAST |=> ptr_ff.x == $past(ptr_ff.x) + 6'h01;
   endproperty
   a_x_step: assert property (p_x_step) else $error("pointer did not advance"); // [R15]
   property p_devsel;
      cmd_done && dec_devsel |=> ptr_ff.sub == $past(rx_byte[3:0]);
   endproperty
   a_devsel: assert property (p_devsel) else $error("subaddress not loaded"); // [R24]
   property p_nack_release;
      st_ff == ST_RDATA && cnt_ff == ACK_END && !pend_ff |-> !oe_ff;
   endproperty
   a_nack_release: assert property (p_nack_release) else $error("master ack slot driven"); // [R6]
   property p_busy_match;
      busy_ff == por_busy;
   endproperty
   a_busy_match: assert property (p_busy_match) else $error("busy flag out of step"); // [R25]

   c_write: cover property (wr_en);
   c_read: cover property (tx_load ##[1:1000] st_ff == ST_IGNORE);
   c_cmd_chain: cover property (cmd_done && rx_byte[CONT_BIT] ##[1:1000] cmd_done);
   c_repeat_start: cover property (st_ff == ST_WDATA ##1 start_det);
endmodule

// ==== testbench/lcdbus_master_model.sv ====
// Behavioural two-wire bus master for the LCD command port bench.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/10ps
module lcdbus_master_model (
   input wire logic i_clk,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_pull
);
   initial begin
      o_scl = 1'b1;
      o_sda_pull = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   // Data moves only while clock is low, one bit a pulse
   // Clock low six cycles, high two, so the slave's answer lands before the rise
   task automatic put_bit(input logic b, output logic s);
      wait_clk(1);
      o_sda_pull = !b;
      wait_clk(5);
      o_scl = 1'b1;
      wait_clk(2);
      s = i_sda;
      o_scl = 1'b0;
   endtask
   // Start only on an idle bus data falls with clock high
   task automatic bus_start();
      while (!(i_sda && o_scl)) wait_clk(1);
      o_sda_pull = 1'b1;
      wait_clk(4);
      o_scl = 1'b0;
      wait_clk(2);
   endtask
   // Data rises with clock high, then the bus idles
   task automatic bus_stop();
      wait_clk(1);
      o_sda_pull = 1'b1;
      wait_clk(5);
      o_scl = 1'b1;
      wait_clk(4);
      o_sda_pull = 1'b0;
      wait_clk(8);
   endtask
   // Eight bits then a released acknowledge pulse
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) put_bit(b[i], s);
      put_bit(1'b1, s);
      ack = !s;
   endtask
   // Acknowledge with data low last byte left unacknowledged
   task automatic get_byte(input logic m_ack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(1'b1, s);
         b[i] = s;
      end
      put_bit(!m_ack, s);
   endtask
endmodule

// ==== testbench/lcd_driver_bus_command_port_tb_top.sv ====
// Self-checking bench for the LCD command port, driving it as bus master.
// Assumes a 10 MHz clock and an 800 ns bus clock from the master model.
`timescale 1ns/10ps
module lcd_driver_bus_command_port_tb_top;
   import lcdbus_pkg::*;
   logic i_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic i_ce = 1'b1;
   logic strap = 1'b0;
   logic [1:0] bank = 2'h0;
   logic [5:0] col = 6'h00;
   logic scl;
   logic pull;
   logic o_sda_out;
   logic o_sda_oe;
   logic o_busy;
   lcdbus_cfg_s o_cfg;
   lcdbus_ptr_s o_ptr;
   logic [7:0] o_disp_data;
   wire sda = (o_sda_oe ? o_sda_out : 1'b1) & !pull;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   always #50 i_clk = ~i_clk;
   lcdbus_port #(.FILT_LEN(2), .POR_CYCLES(20)) dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce),
      .i_scl(scl), .i_sda_in(sda), .i_address_select_strap(strap), .i_disp_bank(bank), .i_disp_col(col),
      .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_busy(o_busy), .o_cfg(o_cfg), .o_ptr(o_ptr),
      .o_disp_data(o_disp_data));
   lcdbus_master_model master_u (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull));
   task automatic final_report();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatch("timeout");
         final_report();
      end
   end
   task automatic mismatch(input string m);
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, m);
   endtask
   task automatic chk_bit(input logic g, input logic e, input string m);
      comparisons++;
      if (g !== e) mismatch(m);
   endtask
   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e, input string m);
      comparisons++;
      if (g !== e) mismatch(m);
   endtask
   task automatic chk_cfg(input lcdbus_cfg_s g, input lcdbus_cfg_s e);
      comparisons++;
      if (g !== e) mismatch("config");
   endtask
   task automatic chk_ptr(input lcdbus_ptr_s g, input lcdbus_ptr_s e);
      comparisons++;
      if (g !== e) mismatch("pointer");
   endtask
   // Sends one byte and judges the acknowledge
   task automatic wr(input logic [7:0] b, input logic e);
      logic a;
      master_u.put_byte(b, a);
      chk_bit(a, e, "acknowledge");
   endtask
   // Looks at one memory byte through the display port
   task automatic show(input logic [1:0] b, input logic [5:0] c, input logic [7:0] e);
      @(negedge i_clk);
      bank = b;
      col = c;
      repeat (2) @(negedge i_clk);
      chk_byte(o_disp_data, e, "display byte");
   endtask
   task automatic t_reset();
      repeat (20) @(negedge i_clk);
      chk_cfg(o_cfg, CFG_RESET);
      chk_ptr(o_ptr, '0);
      chk_bit(o_sda_oe, 1'b0, "data released");
      chk_bit(o_sda_out, 1'b0, "open drain level");
      chk_bit(o_busy, 1'b1, "busy in reset");
      i_nrst = 1'b1;
      for (int i = 0; i < 100 && o_busy !== 1'b0; i++) @(negedge i_clk);
      chk_bit(o_busy, 1'b0, "busy");
      repeat (10) @(negedge i_clk);
      $display("test reset done");
   endtask
   task automatic t_addr();
      master_u.bus_start();
      wr(8'h7A, 1'b0);
      wr(8'h11, 1'b0);
      master_u.bus_stop();
      chk_ptr(o_ptr, '0);
      strap = 1'b1;
      master_u.bus_start();
      wr(8'h78, 1'b0);
      master_u.bus_stop();
      master_u.bus_start();
      wr(8'h7A, 1'b1);
      wr(8'h05, 1'b1);
      master_u.bus_stop();
      chk_ptr(o_ptr, '{sub: 4'h0, y: 2'h0, x: 6'h05});
      strap = 1'b0;
      $display("test address done");
   endtask
   task automatic t_write();
      master_u.bus_start();
      wr(8'h78, 1'b1);
      wr(8'hD5, 1'b1);
      wr(8'hFE, 1'b1);
      wr(8'hF5, 1'b1);
      wr(8'hE0, 1'b1);
      wr(8'h26, 1'b1);
      wr(8'hA1, 1'b1);
      wr(8'hA2, 1'b1);
      wr(8'hA3, 1'b1);
      master_u.bus_stop();
      chk_cfg(o_cfg, '{mixed: 1'b1, status: 2'h1, drive: 2'h1, bank: 2'h2, access: 2'h1});
      chk_ptr(o_ptr, '{sub: 4'h0, y: 2'h2, x: 6'h01});
      show(2'h1, 6'h26, 8'hA1);
      show(2'h1, 6'h27, 8'hA2);
      show(2'h2, 6'h00, 8'h00);
      $display("test write done");
   endtask
   task automatic t_subaddr();
      master_u.bus_start();
      wr(8'h78, 1'b1);
      wr(8'hE3, 1'b1);
      wr(8'hF1, 1'b1);
      wr(8'h26, 1'b1);
      wr(8'h55, 1'b0);
      master_u.bus_stop();
      chk_ptr(o_ptr, '{sub: 4'h3, y: 2'h1, x: 6'h27});
      show(2'h1, 6'h26, 8'hA1);
      $display("test subaddress done");
   endtask
   task automatic t_read();
      logic [7:0] b;
      master_u.bus_start();
      wr(8'h78, 1'b1);
      wr(8'hE0, 1'b1);
      wr(8'hF1, 1'b1);
      wr(8'h26, 1'b1);
      master_u.bus_stop();
      master_u.bus_start();
      wr(8'h79, 1'b1);
      master_u.get_byte(1'b1, b);
      chk_byte(b, 8'hA1, "read first");
      master_u.get_byte(1'b0, b);
      chk_byte(b, 8'hA2, "read second");
      repeat (8) @(negedge i_clk);
      chk_bit(o_sda_oe, 1'b0, "release after no acknowledge");
      master_u.bus_stop();
      chk_ptr(o_ptr, '{sub: 4'h0, y: 2'h2, x: 6'h00});
      $display("test read done");
   endtask
   task automatic t_ce_reset();
      i_ce = 1'b0;
      master_u.bus_start();
      wr(8'h78, 1'b0);
      wr(8'h10, 1'b0);
      master_u.bus_stop();
      i_ce = 1'b1;
      chk_ptr(o_ptr, '{sub: 4'h0, y: 2'h2, x: 6'h00});
      i_nrst = 1'b0;
      t_reset();
      $display("test enable and reset done");
   endtask
   task automatic t_rowmode();
      master_u.bus_start();
      wr(8'h78, 1'b1);
      wr(8'h40, 1'b1);
      master_u.bus_stop();
      chk_bit(o_cfg.mixed, 1'b0, "row mode");
      master_u.bus_start();
      wr(8'h79, 1'b0);
      master_u.bus_stop();
      $display("test row mode done");
   endtask
   initial begin
      t_reset();
      t_addr();
      t_write();
      t_subaddr();
      t_read();
      t_rowmode();
      t_ce_reset();
      final_report();
   end
endmodule
